// File: rtl/sdpr_regs.svh
`ifndef SDPR_REGS_SVH
`define SDPR_REGS_SVH

// array geometry
`define SDPR_ADDR_W          14
`define SDPR_DATA_W          9

// clock and port-to-port timing
`define SDPR_CLK_PERIOD_NS   100
`define SDPR_CROSS_DELAY_NS  30
`define SDPR_CLOCK_SKEW_NS   9
`define SDPR_FLOW_ACCESS_NS  15

// port indices and values
`define SDPR_PORT_A          0
`define SDPR_PORT_B          1
`define SDPR_PORTS           2
`define SDPR_COUNT_STEP      1
`define SDPR_LEVEL_LOW       1'b0
`define SDPR_LEVEL_HIGH      1'b1

`endif

// File: rtl/sdpr_pkg.sv
package sdpr_pkg;

  // burst counter command decoded at a clock edge
  typedef enum logic [1:0] {
    SDPR_CNT_CLEAR,
    SDPR_CNT_LOAD,
    SDPR_CNT_HOLD,
    SDPR_CNT_ADVANCE
  } sdpr_cnt_mode_e;

endpackage

// File: rtl/sdpr_burst_counter.sv
`timescale 1ns/1ps
`include "sdpr_regs.svh"

module sdpr_burst_counter #(
  parameter int ADDR_W = `SDPR_ADDR_W
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    clk_en,
  // counter controls, sampled at the rising edge
  input  wire logic [ADDR_W-1:0]       ext_address,
  input  wire logic                    address_load_strobe_n,
  input  wire logic                    count_advance_n,
  input  wire logic                    count_clear_n,
  // access address for this edge
  output      logic [ADDR_W-1:0]       access_address,
  output      sdpr_pkg::sdpr_cnt_mode_e mode
);
  import sdpr_pkg::*;

  logic [ADDR_W-1:0] count_q;
  logic [ADDR_W-1:0] count_d;

  // no select input reaches this module, so selection cannot disturb it
  always_comb begin
    if (count_clear_n == `SDPR_LEVEL_LOW) begin
      mode           = SDPR_CNT_CLEAR;
      access_address = '0;
    end else if (address_load_strobe_n == `SDPR_LEVEL_LOW) begin
      mode           = SDPR_CNT_LOAD;
      access_address = ext_address;
    end else if (count_advance_n == `SDPR_LEVEL_HIGH) begin
      mode           = SDPR_CNT_HOLD;
      access_address = count_q;
    end else begin
      mode           = SDPR_CNT_ADVANCE;
      // wraps from the last word back to zero
      access_address = count_q + ADDR_W'(`SDPR_COUNT_STEP);
    end
    // clearing still lets the access at location zero go ahead
    count_d = access_address;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      count_q <= '0;
    end else if (clk_en) begin
      count_q <= count_d;
    end
  end

endmodule

// File: rtl/sdpr_dual_port_ram.sv
`timescale 1ns/1ps
`include "sdpr_regs.svh"
module sdpr_dual_port_ram #(
  parameter int ADDR_W = `SDPR_ADDR_W,
  parameter int DATA_W = `SDPR_DATA_W
) (
  // clock, reset, clock enable
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // port a controls
  input  wire logic              a_select_active_low,
  input  wire logic              a_select_active_high,
  input  wire logic              a_write_select_n,
  input  wire logic              a_latency_select,
  input  wire logic              a_output_drive_n,
  // port a address and counter
  input  wire logic [ADDR_W-1:0] a_address,
  input  wire logic              a_address_load_strobe_n,
  input  wire logic              a_count_advance_n,
  input  wire logic              a_count_clear_n,
  // port a data pin
  input  wire logic [DATA_W-1:0] a_data_in,
  output      logic [DATA_W-1:0] a_data_out,
  output      logic              a_data_oe_n,
  // port b controls
  input  wire logic              b_select_active_low,
  input  wire logic              b_select_active_high,
  input  wire logic              b_write_select_n,
  input  wire logic              b_latency_select,
  input  wire logic              b_output_drive_n,
  // port b address and counter
  input  wire logic [ADDR_W-1:0] b_address,
  input  wire logic              b_address_load_strobe_n,
  input  wire logic              b_count_advance_n,
  input  wire logic              b_count_clear_n,
  // port b data pin
  input  wire logic [DATA_W-1:0] b_data_in,
  output      logic [DATA_W-1:0] b_data_out,
  output      logic              b_data_oe_n
);
  import sdpr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // timing derived from the clock rate

  localparam int DEPTH        = 1 << ADDR_W;
  localparam int CROSS_CYCLES = (`SDPR_CROSS_DELAY_NS + `SDPR_CLK_PERIOD_NS - 1)
                                / `SDPR_CLK_PERIOD_NS;
  // both ports share sys_clk, so their skew is zero and within the limit
  localparam int PORT_SKEW_NS = 0;
  localparam bit SKEW_OK      = PORT_SKEW_NS <= `SDPR_CLOCK_SKEW_NS;
  // forwarding makes new data visible to a read of the other port at the same edge as the write
  localparam bit FORWARD      = SKEW_OK && (CROSS_CYCLES <= 1);

  ////////////////////////////////////////////////////////////////////////////////
  // shared array and per-port gathering

  logic [DATA_W-1:0] mem [DEPTH];

  logic [ADDR_W-1:0]  access_address [`SDPR_PORTS];
  sdpr_cnt_mode_e     cnt_mode       [`SDPR_PORTS];
  logic               selected       [`SDPR_PORTS];
  logic               write_hit      [`SDPR_PORTS];
  logic               read_hit       [`SDPR_PORTS];
  logic [DATA_W-1:0]  wr_data        [`SDPR_PORTS];
  logic               latency        [`SDPR_PORTS];
  logic [DATA_W-1:0]  read_value     [`SDPR_PORTS];

  function automatic logic port_selected(input logic sel_low, input logic sel_high);
    port_selected = (sel_low == `SDPR_LEVEL_LOW) && (sel_high == `SDPR_LEVEL_HIGH);
  endfunction

  function automatic logic [DATA_W-1:0] fetch(
    input logic [ADDR_W-1:0] addr,
    input logic              other_write,
    input logic [ADDR_W-1:0] other_addr,
    input logic [DATA_W-1:0] other_data,
    input logic [DATA_W-1:0] stored
  );
    if (FORWARD && other_write && (other_addr == addr)) begin
      fetch = other_data;
    end else begin
      fetch = stored;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // burst counters, one per port

  sdpr_burst_counter #(.ADDR_W(ADDR_W)) u_counter_a (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .clk_en                (clk_en),
    .ext_address           (a_address),
    .address_load_strobe_n (a_address_load_strobe_n),
    .count_advance_n       (a_count_advance_n),
    .count_clear_n         (a_count_clear_n),
    .access_address        (access_address[`SDPR_PORT_A]),
    .mode                  (cnt_mode[`SDPR_PORT_A])
  );

  sdpr_burst_counter #(.ADDR_W(ADDR_W)) u_counter_b (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .clk_en                (clk_en),
    .ext_address           (b_address),
    .address_load_strobe_n (b_address_load_strobe_n),
    .count_advance_n       (b_count_advance_n),
    .count_clear_n         (b_count_clear_n),
    .access_address        (access_address[`SDPR_PORT_B]),
    .mode                  (cnt_mode[`SDPR_PORT_B])
  );

  ////////////////////////////////////////////////////////////////////////////////
  // access decode, sampled at the rising edge

  always_comb begin
    selected[`SDPR_PORT_A]  = port_selected(a_select_active_low, a_select_active_high);
    selected[`SDPR_PORT_B]  = port_selected(b_select_active_low, b_select_active_high);
    write_hit[`SDPR_PORT_A] = selected[`SDPR_PORT_A] && !a_write_select_n;
    write_hit[`SDPR_PORT_B] = selected[`SDPR_PORT_B] && !b_write_select_n;
    read_hit[`SDPR_PORT_A]  = selected[`SDPR_PORT_A] && a_write_select_n;
    read_hit[`SDPR_PORT_B]  = selected[`SDPR_PORT_B] && b_write_select_n;
    wr_data[`SDPR_PORT_A]   = a_data_in;
    wr_data[`SDPR_PORT_B]   = b_data_in;
    latency[`SDPR_PORT_A]   = a_latency_select;
    latency[`SDPR_PORT_B]   = b_latency_select;
    read_value[`SDPR_PORT_A] = fetch(access_address[`SDPR_PORT_A], write_hit[`SDPR_PORT_B],
                                     access_address[`SDPR_PORT_B], b_data_in,
                                     mem[access_address[`SDPR_PORT_A]]);
    read_value[`SDPR_PORT_B] = fetch(access_address[`SDPR_PORT_B], write_hit[`SDPR_PORT_A],
                                     access_address[`SDPR_PORT_A], a_data_in,
                                     mem[access_address[`SDPR_PORT_B]]);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // array writes; on a same-word collision port a is written last and wins

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (write_hit[`SDPR_PORT_B]) begin
        mem[access_address[`SDPR_PORT_B]] <= wr_data[`SDPR_PORT_B];
      end
      if (write_hit[`SDPR_PORT_A]) begin
        mem[access_address[`SDPR_PORT_A]] <= wr_data[`SDPR_PORT_A];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output path: flow stage plus optional pipeline stage

  logic [DATA_W-1:0] flow_data_q [`SDPR_PORTS];
  logic [DATA_W-1:0] flow_data_d [`SDPR_PORTS];
  logic              flow_drv_q  [`SDPR_PORTS];
  logic              flow_drv_d  [`SDPR_PORTS];
  logic [DATA_W-1:0] out_data_q  [`SDPR_PORTS];
  logic [DATA_W-1:0] out_data_d  [`SDPR_PORTS];
  logic              out_drv_q   [`SDPR_PORTS];
  logic              out_drv_d   [`SDPR_PORTS];

  always_comb begin
    for (int p = 0; p < `SDPR_PORTS; p++) begin
      // flow stage holds this edge's read, a read-enable of zero floats the pins
      flow_drv_d[p]  = read_hit[p];
      flow_data_d[p] = read_hit[p] ? read_value[p] : flow_data_q[p];
      if (latency[p]) begin
        // one cycle later: previous-cycle controls set the pin state
        out_drv_d[p]  = flow_drv_q[p];
        out_data_d[p] = flow_data_q[p];
      end else begin
        out_drv_d[p]  = flow_drv_d[p];
        out_data_d[p] = flow_data_d[p];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < `SDPR_PORTS; p++) begin
      if (!reset_n) begin
        flow_data_q[p] <= '0;
        flow_drv_q[p]  <= 1'b0;
        out_data_q[p]  <= '0;
        out_drv_q[p]   <= 1'b0;
      end else if (clk_en) begin
        flow_data_q[p] <= flow_data_d[p];
        flow_drv_q[p]  <= flow_drv_d[p];
        out_data_q[p]  <= out_data_d[p];
        out_drv_q[p]   <= out_drv_d[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins; the drive enable acts without the clock

  assign a_data_out  = out_data_q[`SDPR_PORT_A];
  assign b_data_out  = out_data_q[`SDPR_PORT_B];
  assign a_data_oe_n = a_output_drive_n || !out_drv_q[`SDPR_PORT_A];
  assign b_data_oe_n = b_output_drive_n || !out_drv_q[`SDPR_PORT_B];

  // no-operation cycles are not guarded here; the master rewrites the word

endmodule

// File: dv/sdpr_dual_port_ram_properties.sv
`timescale 1ns/1ps
module sdpr_dual_port_ram_checker #(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 9
) (
  // clock, reset, enable
  input wire logic              sys_clk,
  input wire logic              reset_n,
  input wire logic              clk_en,
  // port a controls
  input wire logic              a_select_active_low,
  input wire logic              a_select_active_high,
  input wire logic              a_write_select_n,
  input wire logic              a_latency_select,
  input wire logic              a_output_drive_n,
  input wire logic              a_address_load_strobe_n,
  input wire logic              a_count_advance_n,
  input wire logic              a_count_clear_n,
  // port b write select, for same-word collisions
  input wire logic              b_write_select_n,
  // port a data pin
  input wire logic [DATA_W-1:0] a_data_out,
  input wire logic              a_data_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire on   = clk_en && !a_select_active_low && a_select_active_high;
  wire rd   = on && a_write_select_n;
  wire ft   = clk_en && !a_latency_select;
  wire pp   = clk_en && a_latency_select;
  wire hold = a_count_clear_n && a_address_load_strobe_n && a_count_advance_n;
  //////////////////////////////////////////////////////////////////////////////
  AST_OE_OFF: assert property (a_output_drive_n |-> a_data_oe_n)
    else $error("data driven with drive disabled");
  AST_FT_DESEL: assert property (clk_en && !on && !a_latency_select |=> a_data_oe_n)
    else $error("deselected port still drives");
  AST_FT_READ: assert property (rd && ft |=> a_output_drive_n || !a_data_oe_n)
    else $error("flow read not driven");
  AST_FT_WRITE: assert property (on && !a_write_select_n && ft |=> a_data_oe_n)
    else $error("write cycle drives data");
  AST_PP_DESEL: assert property (clk_en && !on ##1 pp |=> a_data_oe_n)
    else $error("pipelined deselect not one cycle later");
  AST_PP_READ: assert property (rd ##1 pp |=> a_output_drive_n || !a_data_oe_n)
    else $error("pipelined read not driven");
  AST_HOLD_SAME: assert property (rd && ft ##1 rd && ft && hold && b_write_select_n
    |=> $stable(a_data_out)) else $error("hold moved the access");
  AST_CLEAR_ZERO: assert property ((rd && ft && !a_count_clear_n)[*2] ##0 b_write_select_n
    |=> $stable(a_data_out)) else $error("clear did not reach location zero");
endmodule
bind sdpr_dual_port_ram sdpr_dual_port_ram_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (.*);

// File: dv/sdpr_host_model.sv
`timescale 1ns/1ps
`include "sdpr_regs.svh"
module sdpr_host_model (
  // clock
  input  wire logic                    sys_clk,
  // port a request
  output wire logic                    a_select_active_low,
  output wire logic                    a_select_active_high,
  output wire logic                    a_write_select_n,
  output wire logic                    a_latency_select,
  output wire logic                    a_output_drive_n,
  output wire logic                    a_count_clear_n,
  output wire logic                    a_address_load_strobe_n,
  output wire logic                    a_count_advance_n,
  output wire logic [`SDPR_ADDR_W-1:0] a_address,
  output wire logic [`SDPR_DATA_W-1:0] a_data_in,
  // port b request
  output wire logic                    b_select_active_low,
  output wire logic                    b_select_active_high,
  output wire logic                    b_write_select_n,
  output wire logic                    b_latency_select,
  output wire logic                    b_output_drive_n,
  output wire logic                    b_count_clear_n,
  output wire logic                    b_address_load_strobe_n,
  output wire logic                    b_count_advance_n,
  output wire logic [`SDPR_ADDR_W-1:0] b_address,
  output wire logic [`SDPR_DATA_W-1:0] b_data_in
);
  // idle: deselected, reading, counter holding
  localparam logic [30:0] IDLE = {1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h7, 23'h0};
  logic [30:0] a_req = IDLE;
  logic [30:0] b_req = IDLE;
  assign {a_select_active_low, a_select_active_high, a_write_select_n, a_latency_select,
          a_output_drive_n, a_count_clear_n, a_address_load_strobe_n, a_count_advance_n,
          a_address, a_data_in} = a_req;
  assign {b_select_active_low, b_select_active_high, b_write_select_n, b_latency_select,
          b_output_drive_n, b_count_clear_n, b_address_load_strobe_n, b_count_advance_n,
          b_address, b_data_in} = b_req;
  // one request per edge, held until the next call; callers rewrite after idles
  task automatic cyc(input logic p, s, w, l, o, input logic [2:0] m,
                     input logic [13:0] a, input logic [8:0] d);
    @(posedge sys_clk);
    if (p) begin
      b_req <= {!s, s, w, l, o, m, a, d};
    end else begin
      a_req <= {!s, s, w, l, o, m, a, d};
    end
  endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
`include "sdpr_regs.svh"
module tb;
  localparam logic [2:0] LD = 3'h5, AV = 3'h6, HD = 3'h7, CL = 3'h3;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en  = 1'b1;
  int   err_total  = 0;
  int   n_compared = 0;
  wire logic a_select_active_low, a_select_active_high, a_write_select_n, a_latency_select;
  wire logic a_output_drive_n, a_count_clear_n, a_address_load_strobe_n, a_count_advance_n;
  wire logic b_select_active_low, b_select_active_high, b_write_select_n, b_latency_select;
  wire logic b_output_drive_n, b_count_clear_n, b_address_load_strobe_n, b_count_advance_n;
  wire logic [`SDPR_ADDR_W-1:0] a_address, b_address;
  wire logic [`SDPR_DATA_W-1:0] a_data_in, b_data_in, a_data_out, b_data_out;
  wire logic a_data_oe_n, b_data_oe_n;
  sdpr_dual_port_ram sdpr_dual_port_ram_i (.*);
  sdpr_host_model sdpr_host_model_i (.*);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH time=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compared=%0d mismatches=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic op(input logic p, s, w, l, o, input logic [2:0] m,
                    input logic [13:0] a, input logic [8:0] d);
    sdpr_host_model_i.cyc(p, s, w, l, o, m, a, d);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_pipe;
    op(0, 1, 0, 0, 0, LD, 14'h5, 9'h1A5);
    op(0, 1, 0, 0, 0, LD, 14'h6, 9'h0C3);
    op(0, 1, 1, 0, 0, LD, 14'h5, 9'h000);
    op(0, 1, 1, 1, 0, LD, 14'h6, 9'h000);
    #1 chk(a_data_out, 9'h1A5);
    op(0, 0, 1, 1, 0, HD, 14'h0, 9'h000);
    #1 chk(a_data_out, 9'h1A5);
    chk({8'h00, a_data_oe_n}, 9'h000);
    op(0, 0, 1, 1, 0, HD, 14'h0, 9'h000);
    #1 chk(a_data_out, 9'h0C3);
    chk({8'h00, a_data_oe_n}, 9'h000);
    op(0, 0, 1, 0, 0, HD, 14'h0, 9'h000);
    #1 chk({8'h00, a_data_oe_n}, 9'h001);
    $display("pipelined read test done");
  endtask
  task automatic t_count;
    logic [2:0]  m [6] = '{LD, AV, HD, 3'h0, CL, LD};
    logic [13:0] a [6] = '{14'h3FFF, 14'h0, 14'h5, 14'h3FFF, 14'h7, 14'h2};
    logic [8:0]  e [6] = '{9'h011, 9'h022, 9'h022, 9'h022, 9'h022, 9'h044};
    op(0, 1, 0, 0, 0, LD, 14'h3FFF, 9'h011);
    op(0, 1, 0, 0, 0, AV, 14'h0, 9'h022);
    op(0, 0, 0, 0, 0, AV, 14'h0, 9'h1FF);
    op(0, 1, 0, 0, 0, AV, 14'h0, 9'h044);
    for (int i = 0; i < 6; i++) begin
      op(0, 1, 1, 0, 0, m[i], a[i], 9'h000);
      if (i > 0) begin
        #1 chk(a_data_out, e[i-1]);
      end
    end
    op(0, 0, 1, 0, 0, HD, 14'h0, 9'h000);
    #1 chk(a_data_out, e[5]);
    $display("burst counter test done");
  endtask
  task automatic t_cross;
    fork
      op(1, 1, 0, 0, 0, LD, 14'h9, 9'h1F0);
      op(0, 1, 1, 0, 0, LD, 14'h9, 9'h000);
    join
    fork
      op(1, 1, 1, 0, 0, LD, 14'h9, 9'h000);
      op(0, 0, 1, 0, 0, HD, 14'h0, 9'h000);
    join
    #1 chk(a_data_out, 9'h1F0);
    chk({8'h00, a_data_oe_n}, 9'h000);
    op(0, 1, 1, 0, 0, LD, 14'h9, 9'h000);
    #1 chk({8'h00, a_data_oe_n}, 9'h001);
    chk(b_data_out, 9'h1F0);
    chk({8'h00, b_data_oe_n}, 9'h000);
    op(0, 0, 1, 0, 1, HD, 14'h0, 9'h000);
    #1 chk({8'h00, a_data_oe_n}, 9'h001);
    $display("cross port test done");
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_pipe;
    t_count;
    t_cross;
    report_and_stop;
  end
  initial begin
    repeat (300) @(posedge sys_clk);
    err_total++;
    report_and_stop;
  end
endmodule
